// ---- bench/host_motion_model.sv ----
// host side model: issues one positional command of a set length
`timescale 1ns/1ps
module host_motion_model (
	input  wire logic        aclk,           // control clock
	input  wire logic        start,          // begin one command
	input  wire logic [15:0] len,            // command length in cycles
	output wire logic        pos_cmd_active  // command still moving
);
	logic [15:0] left_q = 16'h0000;

	// count the command down, moving while cycles remain
	always_ff @(posedge aclk) begin
		if (start) begin
			left_q <= len;
		end else if (left_q != 16'h0000) begin
			left_q <= left_q - 16'h0001;
		end
	end
	assign pos_cmd_active = (left_q != 16'h0000);
endmodule : host_motion_model

// ---- bench/observer_and_third_gain_select_bench.sv ----
// self-checking bench of the observer and third gain selector
`timescale 1ns/1ps
module observer_and_third_gain_select_bench import gain_sel_pkg::*; ;
	typedef struct {logic [7:0] a; logic [31:0] d, e; logic [1:0] r;} row_type;
	logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
	logic        bready = 1'b0, arvalid = 1'b0, rready = 1'b0, cmd_go = 1'b0;
	logic        servo_on = 1'b0, gain_switch_on = 1'b1;
	logic        second_gain_cond = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid, observer_active;
	logic        pos_cmd_active;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, got;
	logic [1:0]  bresp, rresp, gain_set, resp, control_mode = 2'b00;
	logic [15:0] kp_active, kv_active, cmd_len = 16'h0000;
	logic signed [15:0] dist_comp, dist_est = 16'sh1000;
	int          fail_count = 0, tests_run = 0, cyc = 0, i;
	row_type     rows [6];
	logic [15:0] rst_vals [6] = '{FEXP_RST, COMP_RST, FILT_RST, VALID_RST,
		SCALE_RST, SWTIME_RST};
	logic [1:0]  modes [5] = '{2'b00, 2'b01, 2'b10, 2'b00, 2'b11};

	observer_and_third_gain_select uut (.aclk, .aresetn, .awaddr, .awvalid,
		.awready, .wdata, .wstrb(4'h3), .wvalid, .wready, .bresp, .bvalid,
		.bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
		.rready, .servo_on, .control_mode, .gain_switch_on,
		.second_gain_cond, .pos_cmd_active, .kp_first(16'h0100),
		.kv_first(16'h0080), .kp_second(16'h0300), .kv_second(16'h0180),
		.dist_estimate(dist_est), .kp_active, .kv_active, .gain_set,
		.observer_active, .dist_comp);
	host_motion_model host (.aclk, .start(cmd_go), .len(cmd_len),
		.pos_cmd_active);

	// clock and hang guard
	always #25 aclk = ~aclk;
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			fail_count++;
			print_verdict();
		end
	end

	task automatic print_verdict();
		$display("checks %0d, mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : print_verdict

	task automatic chk(input string n, input logic [31:0] e, g);
		tests_run++;
		if (g !== e) begin
			$display("BAD %s expected %h seen %h", n, e, g);
			fail_count++;
		end
	endtask : chk

	// wait n edges, then look once outputs have settled
	task automatic step(input int n);
		repeat (n) @(posedge aclk);
		#1;
	endtask : step

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		@(negedge aclk);
		while (!(awready && wready)) @(negedge aclk);
		@(posedge aclk);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		@(negedge aclk);
		while (!bvalid) @(negedge aclk);
		resp = bresp;
		@(posedge aclk);
		bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		@(negedge aclk);
		while (!arready) @(negedge aclk);
		@(posedge aclk);
		arvalid <= 1'b0;
		@(negedge aclk);
		while (!rvalid) @(negedge aclk);
		got = rdata;
		resp = rresp;
		@(posedge aclk);
		rready <= 1'b0;
	endtask : rd

	// second gain wanted, then dropped, with settled looks after each
	task automatic pulse_second();
		@(posedge aclk);
		second_gain_cond <= 1'b1;
		step(3);
		@(posedge aclk);
		second_gain_cond <= 1'b0;
		step(3);
	endtask : pulse_second

	initial begin
		rows = '{
			'{FEXP_OFFSET, 32'h0006, 32'h0006, RESP_OKAY},
			'{COMP_OFFSET, 32'hFF00, 32'hFF9C, RESP_OKAY},
			'{FILT_OFFSET, 32'h0005, 32'h000A, RESP_OKAY},
			'{VALID_OFFSET, 32'h4E20, 32'h2710, RESP_OKAY},
			'{SCALE_OFFSET, 32'h0010, 32'h0032, RESP_OKAY},
			'{8'h1C, 32'h1234, 32'h0000, RESP_SLVERR}};
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		foreach (rst_vals[k]) begin
			rd(8'(k * 4));
			chk("reset value", {16'h0, rst_vals[k]}, got);
		end
		foreach (rows[k]) begin
			wr(rows[k].a, rows[k].d);
			chk("write resp", {30'h0, rows[k].r}, {30'h0, resp});
			rd(rows[k].a);
			chk("read back", rows[k].e, got);
			chk("read resp", {30'h0, rows[k].r}, {30'h0, resp});
		end
		$display("test registers done");
		@(posedge aclk);
		servo_on <= 1'b1;
		for (int k = 0; k < 4; k++) begin
			wr(FEXP_OFFSET, (k == 0) ? 32'h2 : (k == 1) ? 32'h3 : 32'h6 * (k & 1));
			step(3);
			chk("observer", {31'h0, k == 0 || k == 3},
				{31'h0, observer_active});
		end
		$display("test observer done");
		wr(VALID_OFFSET, 32'h0001);
		wr(SCALE_OFFSET, 32'h00C8);
		wr(FEXP_OFFSET, 32'h0006);
		@(posedge aclk);
		cmd_len <= 16'd3000;
		cmd_go <= 1'b1;
		second_gain_cond <= 1'b1;
		@(posedge aclk);
		cmd_go <= 1'b0;
		step(3);
		chk("kp second", 32'h0300, {16'h0, kp_active});
		chk("observer gated", 32'h0, {31'h0, observer_active});
		@(posedge aclk);
		second_gain_cond <= 1'b0;
		step(3);
		chk("third set", {30'h0, GAIN_THIRD}, {30'h0, gain_set});
		chk("kp third", 32'h0200, {16'h0, kp_active});
		chk("kv third", 32'h0100, {16'h0, kv_active});
		step(1000);
		chk("third held", {30'h0, GAIN_THIRD}, {30'h0, gain_set});
		wr(SWTIME_OFFSET, 32'h000A);
		@(posedge aclk);
		second_gain_cond <= 1'b1;
		step(3);
		chk("second wins", {30'h0, GAIN_SECOND}, {30'h0, gain_set});
		@(posedge aclk);
		second_gain_cond <= 1'b0;
		step(3);
		chk("ramping", 32'h1, {31'h0, kp_active > 16'h0200});
		i = 0;
		while (gain_set !== GAIN_FIRST && i < 8000) begin
			step(1);
			i++;
		end
		chk("period end", 32'h1, {31'h0, i >= 1900 && i < 8000});
		for (int k = 0; k < 5; k++) begin
			@(posedge aclk);
			servo_on <= (k != 0);
			control_mode <= modes[k];
			gain_switch_on <= (k != 3);
			cmd_go <= (k == 0);
			pulse_second();
			chk("gain set", (k == 4) ? 32'h2 : 32'h0, {30'h0, gain_set});
		end
		wr(VALID_OFFSET, 32'h0000);
		wr(SCALE_OFFSET, 32'h0064);
		pulse_second();
		chk("third off", {30'h0, GAIN_FIRST}, {30'h0, gain_set});
		$display("test gain selection done");
		@(posedge aclk);
		control_mode <= 2'b00;
		step(3);
		chk("comp", 32'h1, {31'h0, dist_comp <= -16'sh0800
			&& dist_comp >= -16'sh1000});
		@(posedge aclk);
		aresetn <= 1'b0;
		step(2);
		chk("reset gain", 32'h0, {16'h0, kp_active});
		@(posedge aclk);
		aresetn <= 1'b1;
		step(2);
		chk("after reset", 32'h0100, {16'h0, kp_active});
		rd(FEXP_OFFSET);
		chk("fexp reset", {16'h0, FEXP_RST}, got);
		$display("test mid-run reset done");
		print_verdict();
	end
endmodule : observer_and_third_gain_select_bench

// ---- src/dist_filter.sv ----
// first-order lag filter on the disturbance torque estimate
`timescale 1ns/1ps
module dist_filter import gain_sel_pkg::*; (
	input  wire logic               aclk,    // control clock
	input  wire logic               aresetn, // synchronous reset, active low
	input  wire logic               tick,    // 0.01 ms update step
	input  wire logic [15:0]        tau,     // time constant, 0.01 ms units
	input  wire logic signed [15:0] est_in,  // raw disturbance estimate
	output wire logic signed [15:0] est_out  // filtered estimate
);
	logic signed [23:0] acc_q; // 16.8 fixed point state

	// one lag step: acc += (x - acc) / tau
	wire signed [24:0] diff  = $signed({est_in[15], est_in, 8'h00})
		- $signed({acc_q[23], acc_q});
	wire signed [24:0] delta = diff / $signed({9'h000, tau});
	assign est_out = acc_q[23:8];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			acc_q <= 24'h000000;
		end else if (tick) begin
			acc_q <= acc_q + delta[23:0];
		end
	end

	a_filter_holds: assert property (@(posedge aclk) disable iff (!aresetn)
		!tick |=> $stable(acc_q))
		else $error("filter state moved without a step");
endmodule : dist_filter

// ---- src/gain_ramp.sv ----
// linear ramp of one gain from a captured start value to a target value
`timescale 1ns/1ps
module gain_ramp import gain_sel_pkg::*; #(
	parameter int unsigned W = 16
) (
	input  wire logic         aclk,     // control clock
	input  wire logic         aresetn,  // synchronous reset, active low
	input  wire logic         start,    // restart ramp from from_val
	input  wire logic         tick,     // 0.1 ms step
	input  wire logic [15:0]  span,     // ramp length in steps
	input  wire logic [W-1:0] from_val, // value at ramp start
	input  wire logic [W-1:0] to_val,   // final value
	output wire logic [W-1:0] ramp_val  // present ramp value
);
	logic [15:0]  cnt_q;
	logic [W-1:0] from_q;

	// interpolation between start and target
	wire               done = (cnt_q >= span);
	wire signed [W:0]  diff = $signed({1'b0, to_val}) - $signed({1'b0, from_q});
	wire signed [W+17:0] prod = diff * $signed({1'b0, cnt_q});
	wire signed [W+17:0] step = prod / $signed({{(W+2){1'b0}}, span});
	wire signed [W+17:0] mix  = $signed({18'h00000, from_q}) + step;
	assign ramp_val = done ? to_val : mix[W-1:0];

	// step counter and start capture
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q  <= 16'h0000;
			from_q <= '0;
		end else if (start) begin
			cnt_q  <= 16'h0000;
			from_q <= from_val;
		end else if (tick && !done) begin
			cnt_q <= cnt_q + 16'h0001;
		end
	end

	a_ramp_in_range: assert property (@(posedge aclk) disable iff (!aresetn)
		!start |-> ((from_q <= to_val)
			? (ramp_val >= from_q && ramp_val <= to_val)
			: (ramp_val <= from_q && ramp_val >= to_val)))
		else $error("ramp left its interval");
endmodule : gain_ramp

// ---- src/gain_sel_pkg.sv ----
// package: register map, limits, timing and state codes of the gain selector
package gain_sel_pkg;
	// control cycle and derived tick lengths
	localparam int unsigned CLK_PERIOD_NS = 50;
	localparam int unsigned SLOW_TICK_NS  = 100000; // 0.1 ms step
	localparam int unsigned FAST_TICK_NS  = 10000;  // 0.01 ms step
	localparam int unsigned SLOW_TICK_CYC = SLOW_TICK_NS / CLK_PERIOD_NS;
	localparam int unsigned FAST_TICK_CYC = FAST_TICK_NS / CLK_PERIOD_NS;
	localparam int unsigned TICK_CNT_W    = $clog2(SLOW_TICK_CYC);

	// register byte offsets
	localparam logic [7:0] FEXP_OFFSET   = 8'h00;
	localparam logic [7:0] COMP_OFFSET   = 8'h04;
	localparam logic [7:0] FILT_OFFSET   = 8'h08;
	localparam logic [7:0] VALID_OFFSET  = 8'h0C;
	localparam logic [7:0] SCALE_OFFSET  = 8'h10;
	localparam logic [7:0] SWTIME_OFFSET = 8'h14;
	localparam logic [7:0] STATUS_OFFSET = 8'h18;

	// function expansion bit positions
	localparam int unsigned VELOBS_BIT    = 0;
	localparam int unsigned DOBS_EN_BIT   = 1;
	localparam int unsigned DOBS_MODE_BIT = 2;

	// setting limits
	localparam logic [15:0] FEXP_MAX  = 16'h03FF;
	localparam logic [15:0] COMP_MIN  = 16'hFF9C; // -100 percent
	localparam logic [15:0] COMP_MAX  = 16'h0064; // +100 percent
	localparam logic [15:0] FILT_MIN  = 16'h000A;
	localparam logic [15:0] FILT_MAX  = 16'h09C4;
	localparam logic [15:0] VALID_MAX = 16'h2710;
	localparam logic [15:0] SCALE_MIN = 16'h0032;
	localparam logic [15:0] SCALE_MAX = 16'h03E8;
	localparam logic [15:0] SWTIME_MAX = 16'h2710;
	localparam logic [31:0] PCT_DIV   = 32'h0000_0064;

	// reset values
	localparam logic [15:0] FEXP_RST   = 16'h0000;
	localparam logic [15:0] COMP_RST   = 16'h0000;
	localparam logic [15:0] FILT_RST   = 16'h09C4;
	localparam logic [15:0] VALID_RST  = 16'h0000;
	localparam logic [15:0] SCALE_RST  = 16'h0064;
	localparam logic [15:0] SWTIME_RST = 16'h0000;

	// bus responses
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	typedef enum logic [1:0] {
		GAIN_FIRST  = 2'b00,
		GAIN_SECOND = 2'b01,
		GAIN_THIRD  = 2'b10
	} gain_state_type;

	typedef enum logic [1:0] {
		MODE_POSITION    = 2'b00,
		MODE_VELOCITY    = 2'b01,
		MODE_TORQUE      = 2'b10,
		MODE_FULL_CLOSED = 2'b11
	} ctrl_mode_type;
endpackage : gain_sel_pkg

// ---- src/observer_and_third_gain_select.sv ----
// disturbance observer gating and third gain selection with register slave
// Notes on behaviour
// - function expansion bit 1 enables the disturbance observer, 0 disables it.
// - bit 2 zero keeps observer on in every gain set; one only with first gain.
// - compensation scaled by signed percent gain clamped to -100..100.
// - estimate filtered with time constant 10..2500 in 0.01 ms units.
// - third-gain valid time held as 0..10000 in 0.1 ms steps.
// - third gain equals first gain times scale (50..1000) over 100.
// - third gain applied only in position or full-closed control.
// - third period replaces only position and velocity loop gains.
// - second-gain condition during third period selects second gain.
// - second to third gain change ramps over position gain switch time.
// - a return from second to first gain passes a third period only when third_ok holds.
// - third gain switching only while servo is on.
// - third gain only while normal gain switching is operating.
// - disturbance observer only active with velocity observer bit 0 clear.
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module observer_and_third_gain_select import gain_sel_pkg::*; (
	input  wire logic               aclk,             // control clock
	input  wire logic               aresetn,          // sync reset, low
	input  wire logic [7:0]         awaddr,           // write address
	input  wire logic               awvalid,          // write address valid
	output wire logic               awready,          // write address ready
	input  wire logic [31:0]        wdata,            // write data
	input  wire logic [3:0]         wstrb,            // write byte lanes
	input  wire logic               wvalid,           // write data valid
	output wire logic               wready,           // write data ready
	output wire logic [1:0]         bresp,            // write response
	output wire logic               bvalid,           // write response valid
	input  wire logic               bready,           // write response ready
	input  wire logic [7:0]         araddr,           // read address
	input  wire logic               arvalid,          // read address valid
	output wire logic               arready,          // read address ready
	output wire logic [31:0]        rdata,            // read data
	output wire logic [1:0]         rresp,            // read response
	output wire logic               rvalid,           // read data valid
	input  wire logic               rready,           // read data ready
	input  wire logic               servo_on,         // drive energised
	input  wire logic [1:0]         control_mode,     // ctrl_mode_type code
	input  wire logic               gain_switch_on,   // normal switching runs
	input  wire logic               second_gain_cond, // second gain wanted
	input  wire logic               pos_cmd_active,   // position cmd moving
	input  wire logic [15:0]        kp_first,         // first position gain
	input  wire logic [15:0]        kv_first,         // first velocity gain
	input  wire logic [15:0]        kp_second,        // second position gain
	input  wire logic [15:0]        kv_second,        // second velocity gain
	input  wire logic signed [15:0] dist_estimate,    // raw disturbance
	output wire logic [15:0]        kp_active,        // position gain in use
	output wire logic [15:0]        kv_active,        // velocity gain in use
	output wire logic [1:0]         gain_set,         // gain_state_type code
	output wire logic               observer_active,  // observer in use
	output wire logic signed [15:0] dist_comp         // compensation torque
);
	// merge byte lanes into a 16-bit register
	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		merge16 = old;
		if (strb[0]) merge16[7:0] = data[7:0];
		if (strb[1]) merge16[15:8] = data[15:8];
	endfunction : merge16

	// unsigned clamp into a setting range
	function automatic logic [15:0] clamp_u(input logic [15:0] v,
		input logic [15:0] lo, input logic [15:0] hi);
		clamp_u = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction : clamp_u

	// gain times percent scale over 100, saturated to 16 bits
	function automatic logic [15:0] scale_gain(input logic [15:0] g,
		input logic [15:0] s);
		logic [31:0] q;
		q = ({16'h0000, g} * {16'h0000, s}) / PCT_DIV;
		scale_gain = (q > 32'h0000_FFFF) ? 16'hFFFF : q[15:0];
	endfunction : scale_gain

	// register file and bus state
	logic [15:0]    fexp_q, comp_q, filt_q, valid_q, scale_q, swtime_q;
	logic           aw_held_q, w_held_q, bvalid_q, rvalid_q;
	logic [7:0]     waddr_q;
	logic [31:0]    wdata_q, rdata_q;
	logic [3:0]     wstrb_q;
	logic [1:0]     bresp_q, rresp_q;
	gain_state_type state_q, state_d;
	logic [TICK_CNT_W-1:0] slow_cnt_q, fast_cnt_q;
	logic [15:0]    period_cnt_q, kp_q, kv_q;
	logic           obs_q;
	logic signed [15:0] comp_out_q;

	// bus handshakes
	assign awready = !aw_held_q && !bvalid_q;
	assign wready  = !w_held_q && !bvalid_q;
	assign arready = !rvalid_q;
	assign bvalid  = bvalid_q;
	assign bresp   = bresp_q;
	assign rvalid  = rvalid_q;
	assign rresp   = rresp_q;
	assign rdata   = rdata_q;
	wire do_write = aw_held_q && w_held_q && !bvalid_q;
	wire do_read  = arvalid && arready;

	// write address decode
	wire wr_fexp   = do_write && (waddr_q == FEXP_OFFSET);
	wire wr_comp   = do_write && (waddr_q == COMP_OFFSET);
	wire wr_filt   = do_write && (waddr_q == FILT_OFFSET);
	wire wr_valid  = do_write && (waddr_q == VALID_OFFSET);
	wire wr_scale  = do_write && (waddr_q == SCALE_OFFSET);
	wire wr_swtime = do_write && (waddr_q == SWTIME_OFFSET);
	wire wr_hit    = wr_fexp || wr_comp || wr_filt || wr_valid
		|| wr_scale || wr_swtime || (waddr_q == STATUS_OFFSET);

	// signed clamp of the compensation gain
	wire [15:0] comp_new = merge16(comp_q, wdata_q, wstrb_q);
	wire signed [15:0] comp_s = $signed(comp_new);
	wire [15:0] comp_lim = (comp_s < $signed(COMP_MIN)) ? COMP_MIN :
		((comp_s > $signed(COMP_MAX)) ? COMP_MAX : comp_new);

	// status word and read mux
	wire [31:0] status_word = {period_cnt_q, 13'h0000, obs_q, state_q};
	wire [31:0] rd_word =
		(araddr == FEXP_OFFSET)   ? {16'h0000, fexp_q}   :
		(araddr == COMP_OFFSET)   ? {16'h0000, comp_q}   :
		(araddr == FILT_OFFSET)   ? {16'h0000, filt_q}   :
		(araddr == VALID_OFFSET)  ? {16'h0000, valid_q}  :
		(araddr == SCALE_OFFSET)  ? {16'h0000, scale_q}  :
		(araddr == SWTIME_OFFSET) ? {16'h0000, swtime_q} :
		(araddr == STATUS_OFFSET) ? status_word : 32'h0000_0000;
	wire rd_hit = (araddr == FEXP_OFFSET) || (araddr == COMP_OFFSET)
		|| (araddr == FILT_OFFSET) || (araddr == VALID_OFFSET)
		|| (araddr == SCALE_OFFSET) || (araddr == SWTIME_OFFSET)
		|| (araddr == STATUS_OFFSET);

	// write channel capture and response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q <= 1'b0;
			w_held_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= RESP_OKAY;
			waddr_q   <= 8'h00;
			wdata_q   <= 32'h0000_0000;
			wstrb_q   <= 4'h0;
		end else begin
			if (awvalid && awready) begin
				aw_held_q <= 1'b1;
				waddr_q   <= awaddr;
			end
			if (wvalid && wready) begin
				w_held_q <= 1'b1;
				wdata_q  <= wdata;
				wstrb_q  <= wstrb;
			end
			if (do_write) begin
				aw_held_q <= 1'b0;
				w_held_q  <= 1'b0;
				bvalid_q  <= 1'b1;
				bresp_q   <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (bvalid_q && bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// read channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0000_0000;
			rresp_q  <= RESP_OKAY;
		end else if (do_read) begin
			rvalid_q <= 1'b1;
			rdata_q  <= rd_word;
			rresp_q  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_q && rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// settings registers, clamped into range on write
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fexp_q   <= FEXP_RST;
			comp_q   <= COMP_RST;
			filt_q   <= FILT_RST;
			valid_q  <= VALID_RST;
			scale_q  <= SCALE_RST;
			swtime_q <= SWTIME_RST;
		end else begin
			if (wr_fexp)
				fexp_q <= clamp_u(merge16(fexp_q, wdata_q, wstrb_q),
					16'h0000, FEXP_MAX);
			if (wr_comp)
				comp_q <= comp_lim;
			if (wr_filt)
				filt_q <= clamp_u(merge16(filt_q, wdata_q, wstrb_q),
					FILT_MIN, FILT_MAX);
			if (wr_valid)
				valid_q <= clamp_u(merge16(valid_q, wdata_q, wstrb_q),
					16'h0000, VALID_MAX);
			if (wr_scale)
				scale_q <= clamp_u(merge16(scale_q, wdata_q, wstrb_q),
					SCALE_MIN, SCALE_MAX);
			if (wr_swtime)
				swtime_q <= clamp_u(merge16(swtime_q, wdata_q, wstrb_q),
					16'h0000, SWTIME_MAX);
		end
	end

	// 0.1 ms and 0.01 ms tick generators
	wire slow_tick = (slow_cnt_q == TICK_CNT_W'(SLOW_TICK_CYC - 1));
	wire fast_tick = (fast_cnt_q == TICK_CNT_W'(FAST_TICK_CYC - 1));
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			slow_cnt_q <= '0;
			fast_cnt_q <= '0;
		end else begin
			slow_cnt_q <= slow_tick ? '0 : slow_cnt_q + 1'b1;
			fast_cnt_q <= fast_tick ? '0 : fast_cnt_q + 1'b1;
		end
	end

	// third gain qualifiers
	wire mode_third = (control_mode == MODE_POSITION)
		|| (control_mode == MODE_FULL_CLOSED);
	wire third_ok = servo_on
		&& gain_switch_on
		&& mode_third
		&& (valid_q != 16'h0000);
	wire period_done = !pos_cmd_active && (period_cnt_q >= valid_q);

	// gain set selection
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			GAIN_FIRST: begin
				if (second_gain_cond)
					state_d = GAIN_SECOND;
			end
			GAIN_SECOND: begin
				if (!second_gain_cond)
					state_d = third_ok ? GAIN_THIRD : GAIN_FIRST;
			end
			GAIN_THIRD: begin
				if (second_gain_cond)
					state_d = GAIN_SECOND;
				else if (!third_ok || period_done)
					state_d = GAIN_FIRST;
			end
			default: state_d = GAIN_FIRST;
		endcase
	end

	// third period counter: restarts while the command still moves
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q      <= GAIN_FIRST;
			period_cnt_q <= 16'h0000;
		end else begin
			state_q <= state_d;
			if (state_q != GAIN_THIRD || pos_cmd_active)
				period_cnt_q <= 16'h0000;
			else if (slow_tick && period_cnt_q != 16'hFFFF)
				period_cnt_q <= period_cnt_q + 16'h0001;
		end
	end

	// third gains and their ramp from the second set
	wire        ramp_start = (state_d == GAIN_THIRD) && (state_q != GAIN_THIRD);
	wire [15:0] kp_third = scale_gain(kp_first, scale_q);
	wire [15:0] kv_third = scale_gain(kv_first, scale_q);
	wire [15:0] kp_ramp, kv_ramp;

	gain_ramp #(.W(16)) kp_ramp_u (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.start    (ramp_start),
		.tick     (slow_tick),
		.span     (swtime_q),
		.from_val (kp_q),
		.to_val   (kp_third),
		.ramp_val (kp_ramp)
	);

	gain_ramp #(.W(16)) kv_ramp_u (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.start    (ramp_start),
		.tick     (slow_tick),
		.span     (swtime_q),
		.from_val (kv_q),
		.to_val   (kv_third),
		.ramp_val (kv_ramp)
	);

	// disturbance observer gating and compensation
	wire obs_mode = (control_mode == MODE_POSITION)
		|| (control_mode == MODE_VELOCITY);
	wire obs_en = fexp_q[DOBS_EN_BIT]
		&& !fexp_q[VELOBS_BIT]
		&& (!fexp_q[DOBS_MODE_BIT] || state_q == GAIN_FIRST)
		&& servo_on && obs_mode;
	wire signed [15:0] est_filt;
	wire signed [31:0] comp_prod = est_filt * $signed(comp_q);
	wire signed [31:0] comp_pct  = comp_prod / $signed(PCT_DIV);

	dist_filter filt_u (
		.aclk    (aclk),
		.aresetn (aresetn),
		.tick    (fast_tick),
		.tau     (filt_q),
		.est_in  (dist_estimate),
		.est_out (est_filt)
	);

	// registered gain and compensation outputs
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			kp_q       <= 16'h0000;
			kv_q       <= 16'h0000;
			obs_q      <= 1'b0;
			comp_out_q <= 16'sh0000;
		end else begin
			unique case (state_d)
				GAIN_SECOND: begin
					kp_q <= kp_second;
					kv_q <= kv_second;
				end
				GAIN_THIRD: begin
					kp_q <= ramp_start ? kp_q : kp_ramp;
					kv_q <= ramp_start ? kv_q : kv_ramp;
				end
				default: begin
					kp_q <= kp_first;
					kv_q <= kv_first;
				end
			endcase
			obs_q      <= obs_en;
			comp_out_q <= obs_en ? comp_pct[15:0] : 16'sh0000;
		end
	end

	assign kp_active       = kp_q;
	assign kv_active       = kv_q;
	assign gain_set        = state_q;
	assign observer_active = obs_q;
	assign dist_comp       = comp_out_q;

	a_obs_disabled: assert property (@(posedge aclk) disable iff (!aresetn)
		!fexp_q[DOBS_EN_BIT] |=> !obs_q)
		else $error("observer on while disabled");
	a_obs_first_only: assert property (@(posedge aclk) disable iff (!aresetn)
		(fexp_q[DOBS_MODE_BIT] && state_q != GAIN_FIRST) |=> !obs_q)
		else $error("observer on outside first gain");
	a_velobs_blocks: assert property (@(posedge aclk) disable iff (!aresetn)
		fexp_q[VELOBS_BIT] |=> (!obs_q && dist_comp == 16'sh0000))
		else $error("observer on with velocity observer");
	a_comp_range: assert property (@(posedge aclk) disable iff (!aresetn)
		$signed(comp_q) >= -16'sd100 && $signed(comp_q) <= 16'sd100)
		else $error("compensation gain out of range");
	a_filt_range: assert property (@(posedge aclk) disable iff (!aresetn)
		filt_q >= FILT_MIN && filt_q <= FILT_MAX)
		else $error("filter constant out of range");
	a_valid_scale: assert property (@(posedge aclk) disable iff (!aresetn)
		valid_q <= VALID_MAX && scale_q >= SCALE_MIN
		&& scale_q <= SCALE_MAX)
		else $error("third gain setting out of range");
	a_third_qual: assert property (@(posedge aclk) disable iff (!aresetn)
		(!servo_on || !gain_switch_on || !mode_third)
		|=> state_q != GAIN_THIRD)
		else $error("third gain outside allowed conditions");
	a_second_wins: assert property (@(posedge aclk) disable iff (!aresetn)
		(state_q == GAIN_THIRD && second_gain_cond)
		|=> state_q == GAIN_SECOND ##1 kp_q == $past(kp_second))
		else $error("second gain lost to third");
	a_third_inserted: assert property (@(posedge aclk) disable iff (!aresetn)
		(state_q == GAIN_SECOND && !second_gain_cond && third_ok)
		|=> state_q == GAIN_THIRD)
		else $error("third period skipped");
	a_first_gains: assert property (@(posedge aclk) disable iff (!aresetn)
		(state_d == GAIN_FIRST) |=> (kp_q == $past(kp_first)
		&& kv_q == $past(kv_first)))
		else $error("first gains not used");
	a_period_end: assert property (@(posedge aclk) disable iff (!aresetn)
		(state_q == GAIN_THIRD && !second_gain_cond && period_done)
		|=> state_q == GAIN_FIRST)
		else $error("third period overran");
endmodule : observer_and_third_gain_select
